// ===== src/pad_map.svh
// address map constants for the peripheral address decoder
`ifndef PAD_MAP_SVH
`define PAD_MAP_SVH
`define PAD_REG_TOP 24'h000FFF
`define PAD_ID_LO 24'h000000
`define PAD_ID_HI 24'h000003
`define PAD_INT_LO 24'h000010
`define PAD_INT_HI 24'h00001F
`define PAD_MMC_LO 24'h000070
`define PAD_MMC_HI 24'h00008F
`define PAD_DBU_LO 24'h000100
`define PAD_DBU_HI 24'h00017F
`define PAD_PRT_LO 24'h000200
`define PAD_PRT_HI 24'h00037F
`define PAD_FLC_LO 24'h000380
`define PAD_FLC_HI 24'h00039F
`define PAD_ECC_LO 24'h0003C0
`define PAD_ECC_HI 24'h0003CF
`define PAD_FTM_LO 24'h000400
`define PAD_FTM_HI 24'h00042F
`define PAD_PWA_LO 24'h000480
`define PAD_PWA_HI 24'h0004AF
`define PAD_PWB_LO 24'h000500
`define PAD_PWB_HI 24'h00052F
`define PAD_CTM_LO 24'h0005C0
`define PAD_CTM_HI 24'h0005EF
`define PAD_ADC_LO 24'h000600
`define PAD_ADC_HI 24'h00063F
`define PAD_DAC_LO 24'h000680
`define PAD_DAC_HI 24'h000687
`define PAD_CMA_LO 24'h000690
`define PAD_CMA_HI 24'h000697
`define PAD_CMB_LO 24'h000698
`define PAD_CMB_HI 24'h00069F
`define PAD_CPM_LO 24'h0006C0
`define PAD_CPM_HI 24'h0006DF
`define PAD_SUP_LO 24'h0006F0
`define PAD_SUP_HI 24'h0006F7
`define PAD_SEA_LO 24'h000700
`define PAD_SEA_HI 24'h000707
`define PAD_SEB_LO 24'h000710
`define PAD_SEB_HI 24'h000717
`define PAD_SPA_LO 24'h000780
`define PAD_SPA_HI 24'h000787
`define PAD_SPB_LO 24'h000790
`define PAD_SPB_HI 24'h000797
`define PAD_TWI_LO 24'h0007C0
`define PAD_TWI_HI 24'h0007C7
`define PAD_CAN_LO 24'h000800
`define PAD_CAN_HI 24'h00083F
`define PAD_CPY_LO 24'h000990
`define PAD_CPY_HI 24'h000997
`define PAD_SNT_LO 24'h0009A0
`define PAD_SNT_HI 24'h0009AF
`define PAD_SRAM_LO 24'h001000
`define PAD_SRAM_4K 24'h001FFF
`define PAD_SRAM_8K 24'h002FFF
`define PAD_SRAM_12K 24'h003FFF
`define PAD_EE_LO 24'h100000
`define PAD_EE_1K 24'h1003FF
`define PAD_EE_2K 24'h1007FF
`define PAD_FL_HI 24'hFFFFFF
`define PAD_FL_64K 24'hFF0000
`define PAD_FL_96K 24'hFE8000
`define PAD_FL_128K 24'hFE0000
`define PAD_FL_192K 24'hFD0000
`define PAD_VAR_64 2'h0
`define PAD_VAR_96 2'h1
`define PAD_VAR_128 2'h2
`define PAD_VAR_192 2'h3
`define PAD_NSEL 23
`endif

// ===== src/pad_pkg.sv
// types for the peripheral address decoder
package pad_pkg;
    typedef enum logic [4:0] {
        PAD_SEL_NONE = 5'h00,
        PAD_SEL_ID = 5'h01,
        PAD_SEL_MEM = 5'h02,
        PAD_SEL_WIN = 5'h03
    } pad_kind_t;
    typedef struct packed {
        logic [23:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } pad_bus_t;
    typedef struct packed {
        logic [7:0] rdata;
        logic ack;
    } pad_resp_t;
    typedef struct packed {
        logic sram;
        logic eeprom;
        logic flash;
    } pad_mem_t;
    typedef struct packed {
        pad_resp_t resp;
    } pad_state_t;
endpackage

// ===== src/pad_decoder.sv
// peripheral address decoder: module selects, memory routing, part identity
`timescale 1ns/1ps
`include "pad_map.svh"

module pad_decoder
    import pad_pkg::*;
#(
    // arbitrary identity value, not taken from any real part
    parameter logic [31:0] PART_IDENTITY = 32'h1234ABCD
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [1:0] variant_in,
    input wire pad_bus_t bus_in,
    input wire logic [`PAD_NSEL*8-1:0] mod_rdata_in,
    input wire logic [7:0] mem_rdata_in,
    output logic [`PAD_NSEL-1:0] mod_sel_out,
    output pad_mem_t mem_sel_out,
    output logic mod_wr_out,
    output logic mod_rd_out,
    output pad_resp_t resp_out
);
    // select index order: int mmc dbu prt flc ecc ftm pwa pwb ctm adc dac
    // cma cmb cpm sup sea seb spa spb twi can cpy, then sent at bit 22
    function automatic logic in_rng(input logic [23:0] a,
                                    input logic [23:0] lo,
                                    input logic [23:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    pad_state_t state;
    pad_state_t next_state;
    logic [`PAD_NSEL-1:0] sel;
    logic id_hit;
    logic reserved;
    pad_mem_t mem;
    logic [23:0] sram_hi;
    logic [23:0] ee_hi;
    logic [23:0] fl_lo;
    logic [7:0] id_byte;
    logic [7:0] mod_rd;
    logic [7:0] rd_mux;
    logic [23:0] a;

    assign a = bus_in.addr;

    always_comb begin
        sel = '0;
        sel[0] = in_rng(a, `PAD_INT_LO, `PAD_INT_HI);
        sel[1] = in_rng(a, `PAD_MMC_LO, `PAD_MMC_HI);
        sel[2] = in_rng(a, `PAD_DBU_LO, `PAD_DBU_HI);
        sel[3] = in_rng(a, `PAD_PRT_LO, `PAD_PRT_HI);
        sel[4] = in_rng(a, `PAD_FLC_LO, `PAD_FLC_HI);
        sel[5] = in_rng(a, `PAD_ECC_LO, `PAD_ECC_HI);
        sel[6] = in_rng(a, `PAD_FTM_LO, `PAD_FTM_HI);
        sel[7] = in_rng(a, `PAD_PWA_LO, `PAD_PWA_HI);
        sel[8] = in_rng(a, `PAD_PWB_LO, `PAD_PWB_HI);
        sel[9] = in_rng(a, `PAD_CTM_LO, `PAD_CTM_HI);
        sel[10] = in_rng(a, `PAD_ADC_LO, `PAD_ADC_HI);
        sel[11] = in_rng(a, `PAD_DAC_LO, `PAD_DAC_HI);
        sel[12] = in_rng(a, `PAD_CMA_LO, `PAD_CMA_HI);
        sel[13] = in_rng(a, `PAD_CMB_LO, `PAD_CMB_HI);
        sel[14] = in_rng(a, `PAD_CPM_LO, `PAD_CPM_HI);
        sel[15] = in_rng(a, `PAD_SUP_LO, `PAD_SUP_HI);
        sel[16] = in_rng(a, `PAD_SEA_LO, `PAD_SEA_HI);
        sel[17] = in_rng(a, `PAD_SEB_LO, `PAD_SEB_HI);
        sel[18] = in_rng(a, `PAD_SPA_LO, `PAD_SPA_HI);
        sel[19] = in_rng(a, `PAD_SPB_LO, `PAD_SPB_HI);
        sel[20] = in_rng(a, `PAD_TWI_LO, `PAD_TWI_HI);
        // windows are tested directly, so printed overlaps cannot mask them
        sel[21] = in_rng(a, `PAD_CAN_LO, `PAD_CAN_HI);
        sel[22] = in_rng(a, `PAD_CPY_LO, `PAD_CPY_HI) |
                  in_rng(a, `PAD_SNT_LO, `PAD_SNT_HI);
    end

    // sent transmitter hit on its own, for the shared select check
    logic sent_hit;
    assign sent_hit = in_rng(a, `PAD_SNT_LO, `PAD_SNT_HI);

    assign id_hit = in_rng(a, `PAD_ID_LO, `PAD_ID_HI);
    assign reserved = (a <= `PAD_REG_TOP) && !id_hit && (sel == '0);

    always_comb begin
        case (variant_in)
            `PAD_VAR_64: begin
                sram_hi = `PAD_SRAM_4K;
                ee_hi = `PAD_EE_1K;
                fl_lo = `PAD_FL_64K;
            end
            `PAD_VAR_96: begin
                sram_hi = `PAD_SRAM_8K;
                ee_hi = `PAD_EE_2K;
                fl_lo = `PAD_FL_96K;
            end
            `PAD_VAR_128: begin
                sram_hi = `PAD_SRAM_8K;
                ee_hi = `PAD_EE_2K;
                fl_lo = `PAD_FL_128K;
            end
            default: begin
                sram_hi = `PAD_SRAM_12K;
                ee_hi = `PAD_EE_2K;
                fl_lo = `PAD_FL_192K;
            end
        endcase
        mem.sram = in_rng(a, `PAD_SRAM_LO, sram_hi);
        mem.eeprom = in_rng(a, `PAD_EE_LO, ee_hi);
        mem.flash = in_rng(a, fl_lo, `PAD_FL_HI);
    end

    // selects only during an access; reserved space gets no strobe at all
    assign mod_sel_out = (bus_in.rd | bus_in.wr) ? sel : '0;
    assign mem_sel_out = (bus_in.rd | bus_in.wr) ? mem : '0;
    assign mod_wr_out = bus_in.wr & (sel != '0);
    assign mod_rd_out = bus_in.rd & (sel != '0);

    // identity bytes: byte 0 holds the most significant part
    always_comb begin
        case (a[1:0])
            2'h0: id_byte = PART_IDENTITY[31:24];
            2'h1: id_byte = PART_IDENTITY[23:16];
            2'h2: id_byte = PART_IDENTITY[15:8];
            default: id_byte = PART_IDENTITY[7:0];
        endcase
    end

    always_comb begin
        mod_rd = 8'h00;
        for (int i = 0; i < `PAD_NSEL; i++) begin
            if (sel[i]) begin
                mod_rd = mod_rdata_in[i*8 +: 8];
            end
        end
        if (id_hit) begin
            rd_mux = id_byte;
        end else if (reserved) begin
            rd_mux = 8'h00;
        end else if (sel != '0) begin
            rd_mux = mod_rd;
        end else if (mem != '0) begin
            rd_mux = mem_rdata_in;
        end else begin
            rd_mux = 8'h00;
        end
    end

    // one-cycle registered answer; every access, reserved or not, completes
    always_comb begin
        next_state = state;
        next_state.resp.ack = bus_in.rd | bus_in.wr;
        next_state.resp.rdata = bus_in.rd ? rd_mux : 8'h00;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign resp_out = state.resp;

    logic bus_act;
    assign bus_act = bus_in.rd | bus_in.wr;

    one_sel_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        $onehot0(mod_sel_out))
        else $error("multiple selects");
    rsvd_read_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (bus_in.rd && reserved) |=> resp_out.ack && resp_out.rdata == 8'h00)
        else $error("reserved read not zero");
    rsvd_write_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (bus_in.wr && reserved) |-> !mod_wr_out && mod_sel_out == '0)
        else $error("reserved write reached module");
    id_read_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (bus_in.rd && a == `PAD_ID_LO) |=>
        resp_out.rdata == PART_IDENTITY[31:24])
        else $error("identity byte wrong");
    id_write_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (bus_in.wr && id_hit) |-> !mod_wr_out)
        else $error("identity write leaked");
    can_win_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (bus_in.rd && a == `PAD_CAN_LO) |-> mod_sel_out[21])
        else $error("can window lost");
    sent_win_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (bus_in.rd && sent_hit) |-> mod_sel_out[22])
        else $error("sent window not selected");
    flash_top_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (bus_in.rd && a == `PAD_FL_HI) |-> mem_sel_out.flash)
        else $error("flash top unrouted");
    sram_base_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (bus_in.rd && a == `PAD_SRAM_LO) |-> mem_sel_out.sram)
        else $error("sram base unrouted");
    adc_win_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (bus_in.wr && a == `PAD_ADC_HI) |-> mod_sel_out[10])
        else $error("converter window wrong");
    int_win_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (bus_act && a == `PAD_INT_LO) |-> mod_sel_out[0])
        else $error("interrupt window lost");
    mmc_win_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (bus_act && a == `PAD_MMC_HI) |-> mod_sel_out[1])
        else $error("memory mapping window lost");
    dbu_win_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (bus_act && a == `PAD_DBU_LO) |-> mod_sel_out[2])
        else $error("debug window lost");
    prt_win_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (bus_act && a == `PAD_PRT_HI) |-> mod_sel_out[3])
        else $error("port integration window lost");
    flc_win_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (bus_act && a == `PAD_FLC_LO) |-> mod_sel_out[4])
        else $error("flash control window lost");
    ecc_win_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (bus_act && a == `PAD_ECC_HI) |-> mod_sel_out[5])
        else $error("ram ecc window lost");
    ftm_win_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (bus_act && a == `PAD_FTM_LO) |-> mod_sel_out[6])
        else $error("fast timer window lost");
    pwa_win_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (bus_act && a == `PAD_PWA_HI) |-> mod_sel_out[7])
        else $error("first modulator window lost");
    pwb_win_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (bus_act && a == `PAD_PWB_LO) |-> mod_sel_out[8])
        else $error("second modulator window lost");
    ctm_win_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (bus_act && a == `PAD_CTM_HI) |-> mod_sel_out[9])
        else $error("capture timer window lost");
    dac_win_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (bus_act && a == `PAD_DAC_LO) |-> mod_sel_out[11])
        else $error("dac window lost");
    cma_win_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (bus_act && a == `PAD_CMA_HI) |-> mod_sel_out[12])
        else $error("first comparator window lost");
    cmb_win_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (bus_act && a == `PAD_CMB_LO) |-> mod_sel_out[13])
        else $error("second comparator window lost");
    cpm_win_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (bus_act && a == `PAD_CPM_HI) |-> mod_sel_out[14])
        else $error("clock and power window lost");
    sup_win_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (bus_act && a == `PAD_SUP_LO) |-> mod_sel_out[15])
        else $error("supply sensor window lost");
    sea_win_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (bus_act && a == `PAD_SEA_HI) |-> mod_sel_out[16])
        else $error("first serial window lost");
    seb_win_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (bus_act && a == `PAD_SEB_LO) |-> mod_sel_out[17])
        else $error("second serial window lost");
    spa_win_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (bus_act && a == `PAD_SPA_HI) |-> mod_sel_out[18])
        else $error("first spi window lost");
    spb_win_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (bus_act && a == `PAD_SPB_LO) |-> mod_sel_out[19])
        else $error("second spi window lost");
    twi_win_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (bus_act && a == `PAD_TWI_HI) |-> mod_sel_out[20])
        else $error("two-wire window lost");
    cpy_win_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (bus_act && a == `PAD_CPY_LO) |-> mod_sel_out[22])
        else $error("can transceiver window lost");
    gap_rsvd_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (bus_in.rd && a > `PAD_TWI_HI && a < `PAD_CAN_LO) |=>
        resp_out.ack && resp_out.rdata == 8'h00)
        else $error("gap below can window not reserved");
    tail_rsvd_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (bus_in.rd && a > `PAD_SNT_HI && a <= `PAD_REG_TOP) |=>
        resp_out.ack && resp_out.rdata == 8'h00)
        else $error("tail span not reserved");
    resp_ack_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        bus_act |=> resp_out.ack)
        else $error("access not acknowledged");
    mem_data_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (bus_in.rd && mem_sel_out != '0) |=>
        resp_out.rdata == $past(mem_rdata_in))
        else $error("memory read data not returned");
endmodule

// ===== verification/pad_periph_model.sv
// far-side model: module and memory read data
`timescale 1ns/1ps
`include "pad_map.svh"
module pad_periph_model
    import pad_pkg::*;
(
    input wire logic [7:0] salt_in,
    input wire pad_mem_t mem_sel_in,
    output logic [`PAD_NSEL*8-1:0] mod_rdata_out,
    output logic [7:0] mem_rdata_out
);
    // every module answers a distinct byte, salted each cycle,
    // so a wrong route or a stale byte never matches by chance
    always_comb begin
        for (int i = 0; i < `PAD_NSEL; i++)
            mod_rdata_out[i*8 +: 8] = salt_in ^ 8'(i * 8'h11);
        mem_rdata_out = salt_in ^ {5'h00, mem_sel_in};
    end
endmodule

// ===== verification/pad_decoder_tb_top.sv
// self-checking bench for the peripheral address decoder
`timescale 1ns/1ps
`include "pad_map.svh"
module pad_decoder_tb_top
    import pad_pkg::*;
    ;
    // arbitrary identity value
    localparam logic [31:0] ID = 32'h5A3C96E1;
    localparam logic [23:0] MP [23] = '{24'h000FFF, 24'h001000, 24'h001FFF,
        24'h002000, 24'h002FFF, 24'h003000, 24'h003FFF, 24'h004000,
        24'h0FFFFF, 24'h100000, 24'h1003FF, 24'h100400, 24'h1007FF,
        24'h100800, 24'hFCFFFF, 24'hFD0000, 24'hFDFFFF, 24'hFE0000,
        24'hFE7FFF, 24'hFE8000, 24'hFEFFFF, 24'hFF0000, 24'hFFFFFF};
    localparam logic [23:0] LO [24] = '{`PAD_INT_LO, `PAD_MMC_LO,
        `PAD_DBU_LO, `PAD_PRT_LO, `PAD_FLC_LO, `PAD_ECC_LO, `PAD_FTM_LO,
        `PAD_PWA_LO, `PAD_PWB_LO, `PAD_CTM_LO, `PAD_ADC_LO, `PAD_DAC_LO,
        `PAD_CMA_LO, `PAD_CMB_LO, `PAD_CPM_LO, `PAD_SUP_LO, `PAD_SEA_LO,
        `PAD_SEB_LO, `PAD_SPA_LO, `PAD_SPB_LO, `PAD_TWI_LO, `PAD_CAN_LO,
        `PAD_CPY_LO, `PAD_SNT_LO};
    localparam logic [23:0] HI [24] = '{`PAD_INT_HI, `PAD_MMC_HI,
        `PAD_DBU_HI, `PAD_PRT_HI, `PAD_FLC_HI, `PAD_ECC_HI, `PAD_FTM_HI,
        `PAD_PWA_HI, `PAD_PWB_HI, `PAD_CTM_HI, `PAD_ADC_HI, `PAD_DAC_HI,
        `PAD_CMA_HI, `PAD_CMB_HI, `PAD_CPM_HI, `PAD_SUP_HI, `PAD_SEA_HI,
        `PAD_SEB_HI, `PAD_SPA_HI, `PAD_SPB_HI, `PAD_TWI_HI, `PAD_CAN_HI,
        `PAD_CPY_HI, `PAD_SNT_HI};
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [1:0] variant_in = 2'h0;
    pad_bus_t bus_in = '0;
    logic [7:0] salt = 8'h00;
    logic [`PAD_NSEL*8-1:0] mod_rdata;
    logic [7:0] mem_rdata;
    logic [`PAD_NSEL-1:0] mod_sel_out;
    pad_mem_t mem_sel_out;
    logic mod_wr_out;
    logic mod_rd_out;
    pad_resp_t resp_out;
    int errors = 0;
    int checks = 0;
    int cycles = 0;
    // expected read bytes, one per read, taken in order
    logic [7:0] exp_q [$];
    always #50 clk_in = ~clk_in;
    pad_decoder #(.PART_IDENTITY(ID)) pad_decoder_i (.clk_in(clk_in),
        .rst_in(rst_in), .variant_in(variant_in), .bus_in(bus_in),
        .mod_rdata_in(mod_rdata), .mem_rdata_in(mem_rdata),
        .mod_sel_out(mod_sel_out), .mem_sel_out(mem_sel_out),
        .mod_wr_out(mod_wr_out), .mod_rd_out(mod_rd_out),
        .resp_out(resp_out));
    pad_periph_model pad_periph_model_i (.salt_in(salt),
        .mem_sel_in(mem_sel_out), .mod_rdata_out(mod_rdata),
        .mem_rdata_out(mem_rdata));
    task automatic give_verdict;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s,
                       input logic [31:0] e);
        checks++;
        if (s !== e) begin
            errors++;
            $display("ERROR %s expected %0h seen %0h", n, e, s);
        end
    endtask
    // reference decode; the last two table rows share select 22
    function automatic int win(input logic [23:0] a);
        win = -1;
        for (int i = 0; i < 24; i++)
            if (a >= LO[i] && a <= HI[i])
                win = (i > 22) ? 22 : i;
    endfunction
    function automatic logic [2:0] mem(input logic [23:0] a,
                                       input logic [1:0] v);
        logic [23:0] st;
        logic [23:0] et;
        logic [23:0] fl;
        st = (v == 2'h0) ? `PAD_SRAM_4K :
             (v == 2'h3) ? `PAD_SRAM_12K : `PAD_SRAM_8K;
        et = (v == 2'h0) ? `PAD_EE_1K : `PAD_EE_2K;
        fl = (v == 2'h0) ? `PAD_FL_64K : (v == 2'h1) ? `PAD_FL_96K :
             (v == 2'h2) ? `PAD_FL_128K : `PAD_FL_192K;
        mem = {a >= `PAD_SRAM_LO && a <= st, a >= `PAD_EE_LO && a <= et,
               a >= fl};
    endfunction
    // one access cycle; bus is left driven so calls run back to back
    task automatic acc(input logic [23:0] a, input logic r, input logic w);
        int k;
        logic [7:0] ed;
        logic [2:0] em;
        k = win(a);
        em = mem(a, variant_in);
        bus_in = '{addr: a, rd: r, wr: w, wdata: 8'($urandom)};
        salt = 8'($urandom);
        #40;
        chk("sel", 32'(mod_sel_out),
            (k < 0 || !(r || w)) ? 0 : 32'(1) << k);
        chk("mem", 32'(mem_sel_out), (r || w) ? 32'(em) : 0);
        chk("rd", 32'(mod_rd_out), 32'(r && k >= 0));
        chk("wr", 32'(mod_wr_out), 32'(w && k >= 0));
        if (a <= 24'h000003)
            ed = 8'(ID >> (8 * (3 - a[1:0])));
        else if (k >= 0)
            ed = salt ^ 8'(k * 8'h11);
        else if (em != 3'h0)
            ed = salt ^ {5'h00, em};
        else
            ed = 8'h00;
        if (r)
            exp_q.push_back(ed);
        @(posedge clk_in);
        #1;
        chk("ack", 32'(resp_out.ack), 32'(r || w));
        if (r)
            chk("rdata", 32'(resp_out.rdata), 32'(exp_q.pop_front()));
    endtask
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            give_verdict();
        end
    end
    initial begin
        logic [1:0] op;
        void'($urandom(32'h07AF));
        repeat (20) @(posedge clk_in);
        chk("rst", 32'(resp_out), 0);
        #1 rst_in = 1'b0;
        @(posedge clk_in);
        #1;
        // edges and interior of every window; neighbours are reserved except where prt/flc and cma/cmb abut
        for (int i = 0; i < 24; i++) begin
            acc(LO[i], 1'b1, 1'b0);
            acc(HI[i], 1'b0, 1'b1);
            acc(LO[i] - 24'h1, 1'b1, 1'b0);
            acc(HI[i] + 24'h1, 1'b1, 1'b0);
            acc(LO[i] + 24'($urandom % (HI[i] - LO[i] + 1)), 1'b1, 1'b0);
        end
        // identity bytes survive a write attempt
        for (int a = 0; a < 4; a++) begin
            acc(24'(a), 1'b1, 1'b0);
            acc(24'(a), 1'b0, 1'b1);
            acc(24'(a), 1'b1, 1'b0);
        end
        // reset while a read answer stands: it must clear at once
        rst_in = 1'b1;
        #1;
        chk("mid_rst", 32'(resp_out), 0);
        @(posedge clk_in);
        #1;
        rst_in = 1'b0;
        bus_in = '0;
        @(posedge clk_in);
        #1;
        chk("rst_ack", 32'(resp_out), 0);
        for (int v = 0; v < 4; v++) begin
            variant_in = 2'(v);
            foreach (MP[j]) begin
                acc(MP[j], 1'b1, 1'b0);
                acc(MP[j], 1'b0, 1'b1);
            end
        end
        repeat (600) begin
            op = 2'($urandom);
            acc(($urandom % 2) ? 24'($urandom % 4096) : 24'($urandom),
                op[0], op == 2'h2);
        end
        bus_in = '0;
        give_verdict();
    end
endmodule
